// ==== rtl/rmp_pkg.sv ====
/*
  Constants, register map and key codes for the reading math postprocessor.
  Assumes values are signed 32-bit fixed point with four decimal fraction digits.
*/
// Functional notes
// RULE_01 - Scale, percent error or off; light indicator
// RULE_02 - Scale result is reading minus offset over divisor
// RULE_03 - Scale uses offset and divisor operand registers
// RULE_04 - Percent error: (reading-ref)/ref times hundred
// RULE_05 - Over 200,000 counts shows signed over-limit
// RULE_06 - Enter key shows that register's contents
// RULE_07 - Enter opens entry; only blue keys, echoed
// RULE_08 - Operands signed, magnitude up to 199,999.9 (code accepts up to 199,999.9976)
// RULE_09 - Store copies readout, returns to measuring
// RULE_10 - Store while measuring loads displayed reading
// RULE_11 - Store target is the pressed store key
// RULE_12 - High resolution gives 6-1/2 digit readout
// RULE_13 - Integration one or eight line periods
// RULE_14 - No high resolution on AC, .1 V, 1 K
// RULE_15 - Normal resolution gives faster reading rate
// RULE_16 - Zero divisor shows over-limit indication
package rmp_pkg;
  localparam int          MCLK_HZ      = 125_000_000;
  localparam int          MAINS_60_HZ  = 60;
  localparam int          MAINS_50_HZ  = 50;
  localparam logic [3:0]  LINES_NORMAL = 4'h1;
  localparam logic [3:0]  LINES_HIRES  = 4'h8;
  localparam logic [31:0] FIX_SCALE    = 32'h0000_2710;  // 10000 per unit
  localparam logic [31:0] PCT_SCALE    = 32'h000f_4240;  // 100 * FIX_SCALE
  localparam logic [31:0] MAX_OPERAND  = 32'h7735_93e8;  // 199,999.9976
  localparam logic [55:0] OL_LIMIT     = 56'h00_0000_7735_9400; // 200,000
  localparam int          DIV_STEPS    = 56;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_YREG    = 8'h08;
  localparam logic [7:0]  ADDR_ZREG    = 8'h0c;
  localparam logic [7:0]  ADDR_RESULT  = 8'h10;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam int          CTRL_MATH_LO = 0;
  localparam int          CTRL_HIRES   = 2;
  localparam int          CTRL_LINE50  = 3;
  typedef enum logic [1:0] {RMP_MATH_OFF, RMP_MATH_SCALE, RMP_MATH_PCT, RMP_MATH_RSV} rmp_math_t;
  localparam logic [4:0]  KEY_DOT      = 5'h0a;
  localparam logic [4:0]  KEY_SIGN     = 5'h0b;
  localparam logic [4:0]  KEY_ENTER_Y  = 5'h10;
  localparam logic [4:0]  KEY_ENTER_Z  = 5'h11;
  localparam logic [4:0]  KEY_STORE_Y  = 5'h12;
  localparam logic [4:0]  KEY_STORE_Z  = 5'h13;
  localparam logic [4:0]  KEY_SCALE    = 5'h14;
  localparam logic [4:0]  KEY_PCT      = 5'h15;
  localparam logic [4:0]  KEY_MATHOFF  = 5'h16;
  localparam logic [4:0]  KEY_HIRES    = 5'h17;
  localparam logic [3:0]  DIGIT_MAX    = 4'h9;
  localparam logic [31:0] TEN          = 32'h0000_000a;
endpackage

// ==== rtl/rmp_top.sv ====
/*
  Reading math postprocessor: operand registers, keypad entry, scale and
  percent-error arithmetic, over-limit flags and integration timing.
  Assumes key strobes and readings are synchronous one-cycle pulses on MCLK,
  and an APB master that keeps to the usual setup and access phases.
*/
`timescale 1ns/1ns
module rmp_top
  import rmp_pkg::*;
#(
  parameter int LINE60_CYCLES = MCLK_HZ / MAINS_60_HZ,
  parameter int LINE50_CYCLES = MCLK_HZ / MAINS_50_HZ
) (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        KEY_STB,
  input  wire logic [4:0]  KEY_CODE,
  input  wire logic        RDG_VALID,
  input  wire logic [31:0] RDG_VAL,
  input  wire logic        AC_FUNC,
  input  wire logic        LOW_RANGE,
  output logic      [31:0] DISP_VAL,
  output logic             POS_OVER_LIMIT,
  output logic             NEG_OVER_LIMIT,
  output logic             IND_SCALE,
  output logic             IND_PCT,
  output logic             IND_MATH_OFF,
  output logic             ENTRY_MODE,
  output logic             DIGITS_6,
  output logic             INTEG_END
);

  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  function automatic logic [31:0] neg_if(input logic s, input logic [31:0] v);
    neg_if = s ? (~v + 32'h0000_0001) : v;
  endfunction

  typedef enum logic [1:0] {RMP_IDLE, RMP_DIV, RMP_DONE} rmp_state_t;

  //////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] ctrl_q, yreg_q, zreg_q, result_q, disp_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  logic        pos_ol_q, neg_ol_q, entry_q;
  logic        pos_vis_q, neg_vis_q;
  logic [31:0] emag_q, ewt_q;
  logic        eneg_q, edot_q, efresh_q;
  rmp_state_t  st_q;
  logic [55:0] dvd_q;
  logic [32:0] rem_q;
  logic [31:0] dvs_q;
  logic [5:0]  cnt_q;
  logic        qneg_q, dzero_q;
  logic [31:0] integ_q;
  logic [3:0]  lines_q;
  logic        integ_end_q, ind_s_q, ind_p_q, ind_o_q, dig6_q;

  //////////////////////////////////////////////////////////////////////////
  // APB decode
  wire         apb_acc  = PSEL & PENABLE & ~pready_q;
  wire         apb_done = PSEL & PENABLE & pready_q;
  wire         wr_fire  = apb_done & PWRITE & ~pslverr_q;
  wire         hit_ctrl = (PADDR == ADDR_CTRL);
  wire         hit_stat = (PADDR == ADDR_STATUS);
  wire         hit_y    = (PADDR == ADDR_YREG);
  wire         hit_z    = (PADDR == ADDR_ZREG);
  wire         hit_res  = (PADDR == ADDR_RESULT);
  wire         mapped   = hit_ctrl | hit_stat | hit_y | hit_z | hit_res;
  wire         ro_hit   = hit_stat | hit_res;
  wire [31:0]  status_w = {25'h0, dig6_q, (st_q != RMP_IDLE), neg_ol_q, pos_ol_q,
                           entry_q, 2'h0};
  wire [31:0]  rd_mux   = hit_ctrl ? ctrl_q :
                          hit_stat ? status_w :
                          hit_y    ? yreg_q :
                          hit_z    ? zreg_q :
                          hit_res  ? result_q : 32'h0000_0000;
  wire [31:0]  pw_mag   = mag32(PWDATA);
  wire         pw_ok    = (pw_mag <= MAX_OPERAND);                    // RULE_08

  //////////////////////////////////////////////////////////////////////////
  // Mode and resolution
  wire [1:0]   math_sel = ctrl_q[CTRL_MATH_LO +: 2];
  wire         m_scale  = (math_sel == RMP_MATH_SCALE);
  wire         m_pct    = (math_sel == RMP_MATH_PCT);
  wire         m_off    = ~m_scale & ~m_pct;                          // RULE_01
  wire         hires    = ctrl_q[CTRL_HIRES] & ~AC_FUNC & ~LOW_RANGE; // RULE_14
  wire [31:0]  line_cyc = ctrl_q[CTRL_LINE50] ? LINE50_CYCLES : LINE60_CYCLES;
  wire [3:0]   lines_n  = hires ? LINES_HIRES : LINES_NORMAL;         // RULE_13

  //////////////////////////////////////////////////////////////////////////
  // Keypad decode
  wire         is_digit = KEY_STB & (KEY_CODE[4] == 1'b0) & (KEY_CODE[3:0] <= DIGIT_MAX)
                          & ~KEY_CODE[4];
  wire         k_dot    = KEY_STB & (KEY_CODE == KEY_DOT);
  wire         k_sign   = KEY_STB & (KEY_CODE == KEY_SIGN);
  wire         k_ent_y  = KEY_STB & (KEY_CODE == KEY_ENTER_Y);
  wire         k_ent_z  = KEY_STB & (KEY_CODE == KEY_ENTER_Z);
  wire         k_sto_y  = KEY_STB & (KEY_CODE == KEY_STORE_Y);
  wire         k_sto_z  = KEY_STB & (KEY_CODE == KEY_STORE_Z);
  wire         k_math   = ~entry_q & KEY_STB &                           // RULE_07
                          ((KEY_CODE == KEY_SCALE) | (KEY_CODE == KEY_PCT) |
                           (KEY_CODE == KEY_MATHOFF));
  wire         k_hires  = ~entry_q & KEY_STB & (KEY_CODE == KEY_HIRES); // RULE_07
  wire         k_enter  = k_ent_y | k_ent_z;
  wire         k_store  = k_sto_y | k_sto_z;
  wire [1:0]   key_math = (KEY_CODE == KEY_SCALE) ? RMP_MATH_SCALE :
                          (KEY_CODE == KEY_PCT)   ? RMP_MATH_PCT : RMP_MATH_OFF;

  //////////////////////////////////////////////////////////////////////////
  // Numeric entry
  wire [31:0]  e_base   = efresh_q ? 32'h0000_0000 : emag_q;
  wire         e_dot    = efresh_q ? 1'b0 : edot_q;
  wire [31:0]  e_wt     = efresh_q ? FIX_SCALE : ewt_q;
  wire [31:0]  dval     = {28'h0, KEY_CODE[3:0]};
  wire [35:0]  cand_int = 36'(e_base) * 36'(TEN) + 36'(dval) * 36'(FIX_SCALE);
  wire [35:0]  cand_frc = 36'(e_base) + 36'(dval) * 36'(e_wt);
  wire [35:0]  cand     = e_dot ? cand_frc : cand_int;
  wire         frc_room = ~e_dot | (e_wt != 32'h0000_0000);
  wire         dig_ok   = entry_q & is_digit & frc_room &
                          (cand <= 36'(MAX_OPERAND));                  // RULE_08
  wire [31:0]  ewt_next = e_dot ? (e_wt / TEN) : e_wt;
  wire [31:0]  entry_val = neg_if(eneg_q, emag_q);
  wire [31:0]  enter_src = k_ent_y ? yreg_q : zreg_q;

  //////////////////////////////////////////////////////////////////////////
  // Math datapath setup
  wire [31:0]  ref_val  = m_pct ? yreg_q : zreg_q;                     // RULE_03
  wire [32:0]  numer    = {RDG_VAL[31], RDG_VAL} - {ref_val[31], ref_val}; // RULE_02
  wire         num_neg  = numer[32];
  wire [32:0]  num_mag  = num_neg ? (~numer + 33'h0_0000_0001) : numer;
  wire [31:0]  mult     = m_pct ? PCT_SCALE : FIX_SCALE;               // RULE_04
  wire [55:0]  dvd_init = 56'(num_mag) * 56'(mult);
  wire [31:0]  y_mag    = mag32(yreg_q);
  wire         start    = RDG_VALID & (st_q == RMP_IDLE);
  wire [32:0]  rem_sh   = {rem_q[31:0], dvd_q[55]};
  wire         rem_ge   = (rem_sh >= {1'b0, dvs_q});
  wire [32:0]  rem_nx   = rem_ge ? (rem_sh - {1'b0, dvs_q}) : rem_sh;
  wire         q_over   = (dvd_q > OL_LIMIT);
  wire [31:0]  x_mag    = mag32(RDG_VAL);
  wire         x_over   = ({24'h0, x_mag} > OL_LIMIT);
  wire         ol_x     = start & m_off;
  wire         ol_div   = (st_q == RMP_DONE);
  wire         pos_nx   = ol_x   ? (x_over & ~RDG_VAL[31]) :
                          ol_div ? ((dzero_q | q_over) & ~qneg_q) : pos_ol_q; // RULE_05
  wire         neg_nx   = ol_x   ? (x_over & RDG_VAL[31]) :
                          ol_div ? ((dzero_q | q_over) & qneg_q) : neg_ol_q;  // RULE_16
  wire         entry_nx = ~k_store & (k_enter | entry_q);

  //////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, error on unmapped access or read-only write
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_acc;
      pslverr_q <= apb_acc & (~mapped | (PWRITE & ro_hit));
      if (apb_acc & ~PWRITE) begin
        prdata_q <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register and operand registers
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= CTRL_RESET;
    end else if (k_math) begin
      ctrl_q[CTRL_MATH_LO +: 2] <= key_math;                           // RULE_01
    end else if (k_hires) begin
      ctrl_q[CTRL_HIRES] <= ~ctrl_q[CTRL_HIRES];
    end else if (wr_fire & hit_ctrl) begin
      ctrl_q <= {28'h0, PWDATA[3:0]};
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      yreg_q <= 32'h0000_0000;
      zreg_q <= 32'h0000_0000;
    end else begin
      if (k_sto_y) begin
        yreg_q <= disp_q;                                              // RULE_11
      end else if (wr_fire & hit_y & pw_ok) begin
        yreg_q <= PWDATA;
      end
      if (k_sto_z) begin
        zreg_q <= disp_q;                                              // RULE_11
      end else if (wr_fire & hit_z & pw_ok) begin
        zreg_q <= PWDATA;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Entry mode and entry accumulator
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      entry_q  <= 1'b0;
      emag_q   <= 32'h0000_0000;
      eneg_q   <= 1'b0;
      edot_q   <= 1'b0;
      ewt_q    <= FIX_SCALE;
      efresh_q <= 1'b1;
    end else if (k_store) begin
      entry_q <= 1'b0;                                                 // RULE_09
    end else if (k_enter) begin
      entry_q  <= 1'b1;                                                // RULE_07
      emag_q   <= mag32(enter_src);                                    // RULE_06
      eneg_q   <= enter_src[31];
      efresh_q <= 1'b1;
    end else if (dig_ok) begin
      emag_q   <= cand[31:0];                                          // RULE_07
      edot_q   <= e_dot;
      ewt_q    <= ewt_next;
      eneg_q   <= efresh_q ? 1'b0 : eneg_q;
      efresh_q <= 1'b0;
    end else if (entry_q & k_dot & ~(edot_q & ~efresh_q)) begin
      emag_q   <= e_base;
      edot_q   <= 1'b1;
      ewt_q    <= FIX_SCALE / TEN;
      eneg_q   <= efresh_q ? 1'b0 : eneg_q;
      efresh_q <= 1'b0;
    end else if (entry_q & k_sign) begin
      eneg_q   <= ~eneg_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequential divider for scale and percent error
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      st_q    <= RMP_IDLE;
      dvd_q   <= 56'h0;
      rem_q   <= 33'h0;
      dvs_q   <= 32'h0000_0000;
      cnt_q   <= 6'h0;
      qneg_q  <= 1'b0;
      dzero_q <= 1'b0;
    end else begin
      case (st_q)
        RMP_IDLE: begin
          if (start & ~m_off) begin
            dvd_q   <= dvd_init;
            rem_q   <= 33'h0;
            dvs_q   <= y_mag;                                          // RULE_03
            cnt_q   <= 6'(DIV_STEPS - 1);
            qneg_q  <= num_neg ^ yreg_q[31];
            dzero_q <= (y_mag == 32'h0000_0000);                       // RULE_16
            st_q    <= RMP_DIV;
          end
        end
        RMP_DIV: begin
          dvd_q <= {dvd_q[54:0], rem_ge};
          rem_q <= rem_nx;
          cnt_q <= cnt_q - 6'h1;
          if (cnt_q == 6'h0) begin
            st_q <= RMP_DONE;
          end
        end
        RMP_DONE: begin
          st_q <= RMP_IDLE;
        end
        default: begin
          st_q <= RMP_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result, readout and over-limit flags
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      result_q <= 32'h0000_0000;
      pos_ol_q <= 1'b0;
      neg_ol_q <= 1'b0;
      pos_vis_q <= 1'b0;
      neg_vis_q <= 1'b0;
      disp_q   <= 32'h0000_0000;
    end else begin
      pos_ol_q  <= pos_nx;
      neg_ol_q  <= neg_nx;
      // Flags hidden while an entry is on the readout
      pos_vis_q <= pos_nx & ~entry_nx;                                 // RULE_05
      neg_vis_q <= neg_nx & ~entry_nx;
      if (ol_x) begin
        result_q <= RDG_VAL;
      end else if (ol_div) begin
        result_q <= neg_if(qneg_q, dvd_q[31:0]);                       // RULE_02
      end
      if (k_enter) begin
        disp_q <= enter_src;                                           // RULE_06
      end else if (entry_q) begin
        disp_q <= entry_val;                                           // RULE_07
      end else if (start & m_off) begin
        disp_q <= RDG_VAL;                                             // RULE_10
      end else if (st_q == RMP_DONE) begin
        disp_q <= neg_if(qneg_q, dvd_q[31:0]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Integration timer and indicators
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      integ_q     <= 32'h0000_0000;
      lines_q     <= 4'h0;
      integ_end_q <= 1'b0;
      ind_s_q     <= 1'b0;
      ind_p_q     <= 1'b0;
      ind_o_q     <= 1'b1;
      dig6_q      <= 1'b0;
    end else begin
      ind_s_q <= m_scale;                                              // RULE_01
      ind_p_q <= m_pct;
      ind_o_q <= m_off;
      dig6_q  <= hires;                                                // RULE_12
      integ_end_q <= 1'b0;
      if (integ_q + 32'h0000_0001 >= line_cyc) begin
        integ_q <= 32'h0000_0000;
        if (lines_q + 4'h1 >= lines_n) begin
          lines_q     <= 4'h0;
          integ_end_q <= 1'b1;                                         // RULE_15
        end else begin
          lines_q <= lines_q + 4'h1;                                   // RULE_13
        end
      end else begin
        integ_q <= integ_q + 32'h0000_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA         = prdata_q;
  assign PREADY         = pready_q;
  assign PSLVERR        = pslverr_q;
  assign DISP_VAL       = disp_q;
  assign POS_OVER_LIMIT = pos_vis_q;
  assign NEG_OVER_LIMIT = neg_vis_q;
  assign IND_SCALE      = ind_s_q;
  assign IND_PCT        = ind_p_q;
  assign IND_MATH_OFF   = ind_o_q;
  assign ENTRY_MODE     = entry_q;
  assign DIGITS_6       = dig6_q;
  assign INTEG_END      = integ_end_q;

endmodule

// ==== testbench/rmp_panel.sv ====
/*
  Front panel model: keypad strobes and measurement readings.
  Assumes the caller starts each task anywhere; drives follow a rising edge.
*/
`timescale 1ns/1ns
module rmp_panel (
  input  wire logic        mclk,
  output logic             key_stb,
  output logic      [4:0]  key_code,
  output logic             rdg_valid,
  output logic      [31:0] rdg_val
);
  initial begin
    key_stb   = 1'b0;
    key_code  = 5'h1f;
    rdg_valid = 1'b0;
    rdg_val   = 32'h0;
  end
  // Released lines show the inverse, never the stale value
  task automatic press(input logic [4:0] c);
    @(posedge mclk);
    key_stb  <= 1'b1;
    key_code <= c;
    @(posedge mclk);
    key_stb  <= 1'b0;
    key_code <= ~c;
  endtask
  task automatic rdg(input logic [31:0] v);
    @(posedge mclk);
    rdg_valid <= 1'b1;
    rdg_val   <= v;
    @(posedge mclk);
    rdg_valid <= 1'b0;
    rdg_val   <= ~v;
  endtask
endmodule

// ==== testbench/rmp_props.sv ====
/*
  Checker for the reading math postprocessor, watching top-level ports only.
  Assumes one clock MCLK and the asynchronous active-high RESET.
*/
`timescale 1ns/1ns
module rmp_props
  import rmp_pkg::*;
#(
  parameter int LINE60_CYCLES = 10,
  parameter int LINE50_CYCLES = 12
) (
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        KEY_STB,
  input wire logic [4:0]  KEY_CODE,
  input wire logic        RDG_VALID,
  input wire logic [31:0] RDG_VAL,
  input wire logic        AC_FUNC,
  input wire logic        LOW_RANGE,
  input wire logic [31:0] DISP_VAL,
  input wire logic        POS_OVER_LIMIT,
  input wire logic        NEG_OVER_LIMIT,
  input wire logic        IND_SCALE,
  input wire logic        IND_PCT,
  input wire logic        IND_MATH_OFF,
  input wire logic        ENTRY_MODE,
  input wire logic        DIGITS_6,
  input wire logic        INTEG_END
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  wire         enter_k = KEY_STB && (KEY_CODE == KEY_ENTER_Y || KEY_CODE == KEY_ENTER_Z);
  wire         store_k = KEY_STB && (KEY_CODE == KEY_STORE_Y || KEY_CODE == KEY_STORE_Z);
  logic [31:0] gap_q;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last integration end
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) gap_q <= 32'h0;
    else if (INTEG_END) gap_q <= 32'h0;
    else gap_q <= gap_q + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_ind_onehot: assert property ($onehot({IND_SCALE, IND_PCT, IND_MATH_OFF}))
    else $error("math indicators not one-hot");
  chk_math_off_pass: assert property (RDG_VALID && IND_MATH_OFF && !ENTRY_MODE
    |=> DISP_VAL == $past(RDG_VAL)) else $error("math off reading not shown");
  chk_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready not one cycle after access");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_enter_entry: assert property (enter_k |=> ENTRY_MODE)
    else $error("enter did not open entry");
  chk_store_exit: assert property (store_k |=> !ENTRY_MODE)
    else $error("store did not end entry");
  chk_flag_gate: assert property ((ENTRY_MODE || POS_OVER_LIMIT) |-> !NEG_OVER_LIMIT
    && !(ENTRY_MODE && POS_OVER_LIMIT)) else $error("over-limit flags conflict");
  chk_hires_block: assert property ((AC_FUNC || LOW_RANGE) [*2] |-> !DIGITS_6)
    else $error("high resolution not blocked");
  chk_integ_bound: assert property (gap_q < 8 * LINE50_CYCLES)
    else $error("integration period too long");
  cover property (enter_k ##1 ENTRY_MODE);
  cover property (POS_OVER_LIMIT);
  cover property (NEG_OVER_LIMIT);
  cover property (DIGITS_6 && INTEG_END);
endmodule
bind rmp_top rmp_props #(.LINE60_CYCLES(LINE60_CYCLES), .LINE50_CYCLES(LINE50_CYCLES)) u_props (
  .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .KEY_STB(KEY_STB), .KEY_CODE(KEY_CODE), .RDG_VALID(RDG_VALID),
  .RDG_VAL(RDG_VAL), .AC_FUNC(AC_FUNC), .LOW_RANGE(LOW_RANGE), .DISP_VAL(DISP_VAL),
  .POS_OVER_LIMIT(POS_OVER_LIMIT), .NEG_OVER_LIMIT(NEG_OVER_LIMIT), .IND_SCALE(IND_SCALE),
  .IND_PCT(IND_PCT), .IND_MATH_OFF(IND_MATH_OFF), .ENTRY_MODE(ENTRY_MODE),
  .DIGITS_6(DIGITS_6), .INTEG_END(INTEG_END));

// ==== testbench/rmp_top_tb.sv ====
/*
  Self-checking bench: APB register tasks, keypad and reading stimulus.
  Assumes shortened line periods of 10 and 12 cycles.
*/
`timescale 1ns/1ns
module rmp_top_tb;
  import rmp_pkg::*;
  localparam int L60 = 10;
  localparam int L50 = 12;
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, ac, lowr;
  logic        kstb, rvld, pos, neg, i_sc, i_pc, i_off, entry, d6, integ, rerr;
  logic [4:0]  kcode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rval, disp, rdat;
  int          miscompares, n_compared, n;
  rmp_top #(.LINE60_CYCLES(L60), .LINE50_CYCLES(L50)) dut (
    .MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .KEY_STB(kstb), .KEY_CODE(kcode), .RDG_VALID(rvld), .RDG_VAL(rval), .AC_FUNC(ac),
    .LOW_RANGE(lowr), .DISP_VAL(disp), .POS_OVER_LIMIT(pos), .NEG_OVER_LIMIT(neg),
    .IND_SCALE(i_sc), .IND_PCT(i_pc), .IND_MATH_OFF(i_off), .ENTRY_MODE(entry),
    .DIGITS_6(d6), .INTEG_END(integ));
  rmp_panel u_panel (.mclk(mclk), .key_stb(kstb), .key_code(kcode), .rdg_valid(rvld),
    .rdg_val(rval));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic gap(output int m);
    for (int i = 0; i < 200 && integ !== 1'b1; i++) @(posedge mclk);
    m = 0;
    do begin
      @(posedge mclk);
      m++;
    end while (integ !== 1'b1 && m < 200);
  endtask
  task automatic gchk(input int e);
    gap(n);
    gap(n);
    chk(32'(n), 32'(e));
  endtask
  task automatic run_case(input logic [4:0] k, input logic [31:0] y, z, x, e,
                          input logic [1:0] f);
    apb(1'b1, ADDR_YREG, y);
    apb(1'b1, ADDR_ZREG, z);
    u_panel.press(k);
    u_panel.rdg(x);
    step(60);
    chk({30'h0, pos, neg}, {30'h0, f});
    if (f == 2'b00) chk(disp, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    n_compared  = 0;
    reset = 1'b1;
    {psel, penable, pwrite, ac, lowr} = 5'h0;
    paddr  = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat, CTRL_RESET);
    chk({29'h0, i_sc, i_pc, i_off}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h1);
    chk(32'(rerr), 32'h1);
    apb(1'b1, ADDR_YREG, 32'h7735_93e8);
    apb(1'b1, ADDR_YREG, 32'h7735_93e9);
    apb(1'b0, ADDR_YREG, 32'h0);
    chk(rdat, MAX_OPERAND);
    apb(1'b1, ADDR_ZREG, -MAX_OPERAND);
    apb(1'b0, ADDR_ZREG, 32'h0);
    chk(rdat, -MAX_OPERAND);
    $display("test reset and limits done");
    u_panel.press(KEY_ENTER_Y);
    step(1);
    chk({31'h0, entry}, 32'h1);
    chk(disp, MAX_OPERAND);
    u_panel.press(KEY_PCT);
    u_panel.press(5'h01);
    u_panel.press(5'h02);
    u_panel.press(KEY_DOT);
    u_panel.press(5'h05);
    step(2);
    chk(disp, 32'd125000);
    u_panel.press(KEY_STORE_Z);
    step(1);
    chk({31'h0, entry}, 32'h0);
    chk({29'h0, i_sc, i_pc, i_off}, 32'h1);
    apb(1'b0, ADDR_ZREG, 32'h0);
    chk(rdat, 32'd125000);
    u_panel.press(KEY_ENTER_Z);
    step(1);
    chk(disp, 32'd125000);
    u_panel.press(KEY_SIGN);
    step(2);
    chk(disp, -32'd125000);
    u_panel.press(KEY_STORE_Z);
    u_panel.rdg(32'd30000);
    step(1);
    chk(disp, 32'd30000);
    u_panel.press(KEY_STORE_Y);
    apb(1'b0, ADDR_YREG, 32'h0);
    chk(rdat, 32'd30000);
    $display("test keypad done");
    run_case(KEY_SCALE, 32'd20000, 32'd10000, 32'd50000, 32'd20000, 2'b00);
    chk({29'h0, i_sc, i_pc, i_off}, 32'h4);
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk(rdat, 32'd20000);
    run_case(KEY_SCALE, 32'd10000, 32'd0, 32'h7735_9400, 32'h7735_9400, 2'b00);
    run_case(KEY_SCALE, 32'd10000, 32'd0, 32'h7735_9401, 32'h0, 2'b10);
    run_case(KEY_SCALE, 32'd10000, 32'd0, -32'h7735_9401, 32'h0, 2'b01);
    run_case(KEY_SCALE, 32'd0, 32'd0, 32'd50000, 32'h0, 2'b10);
    run_case(KEY_PCT, 32'd7500, 32'd0, 32'd7900, 32'd53333, 2'b00);
    run_case(KEY_PCT, 32'd10000, 32'd0, 32'd5000, -32'd500000, 2'b00);
    chk({29'h0, i_sc, i_pc, i_off}, 32'h2);
    u_panel.press(KEY_MATHOFF);
    step(1);
    chk({29'h0, i_sc, i_pc, i_off}, 32'h1);
    $display("test math done");
    apb(1'b1, ADDR_CTRL, 32'h4);
    step(2);
    chk({31'h0, d6}, 32'h1);
    gchk(8 * L60);
    @(posedge mclk);
    lowr <= 1'b1;
    step(2);
    chk({31'h0, d6}, 32'h0);
    gchk(L60);
    @(posedge mclk);
    lowr <= 1'b0;
    ac   <= 1'b1;
    step(2);
    chk({31'h0, d6}, 32'h0);
    @(posedge mclk);
    ac <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'hc);
    step(2);
    chk({31'h0, d6}, 32'h1);
    gchk(8 * L50);
    apb(1'b1, ADDR_CTRL, 32'h8);
    gchk(L50);
    u_panel.press(KEY_HIRES);
    step(1);
    chk({31'h0, d6}, 32'h1);
    $display("test resolution done");
    tally_and_finish();
  end
endmodule
